// file: include/amw_pkg.sv
// Package of timing constants, states and carrier types for the memory write controller
`default_nettype none
package amw_pkg;
   // Clock rate and period
   localparam int CLK_MHZ            = 20;
   localparam int CLK_PERIOD_NS      = 1000 / CLK_MHZ;
   // Interval limits in nanoseconds, startup wait in microseconds
   localparam int CYCLE_TIME_MIN_NS  = 35;
   localparam int STROBE_WIDTH_NS    = 15;
   localparam int ADDR_TO_END_G_HI   = 18;
   localparam int ADDR_TO_END_G_LO   = 20;
   localparam int DATA_SETUP_MIN_NS  = 10;
   localparam int WRITE_RECOVERY_NS  = 12;
   localparam int HIGH_HOLD_NS       = 2;
   localparam int STARTUP_WAIT_US    = 2000;
   // Least times rounded up to whole cycles
   localparam int STROBE_CYC   = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDR_END_CYC = (ADDR_TO_END_G_LO + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DATA_CYC     = (DATA_SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_CYC_RAW  = (STROBE_CYC > ADDR_END_CYC) ? STROBE_CYC : ADDR_END_CYC;
   localparam int LOW_CYC      = (LOW_CYC_RAW > DATA_CYC) ? LOW_CYC_RAW : DATA_CYC;
   localparam int REC_CYC_RAW  = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HIGH_CYC     = (HIGH_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REC_CYC      = (REC_CYC_RAW > HIGH_CYC) ? REC_CYC_RAW : HIGH_CYC;
   localparam int CYCLE_CYC    = (CYCLE_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STARTUP_CYC  = STARTUP_WAIT_US * CLK_MHZ;
   // Widths
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int CNT_W  = 16;
   localparam int WAIT_W = 24;

   // Controller states, one-hot
   typedef enum logic [4:0] {
      ST_STARTUP = 5'h01,
      ST_IDLE    = 5'h02,
      ST_SETUP   = 5'h04,
      ST_LOW     = 5'h08,
      ST_RECOVER = 5'h10
   } amw_state_type;

   // How the write is bounded
   typedef enum logic [1:0] {
      TERM_STROBE = 2'h0,
      TERM_SELECT = 2'h1,
      TERM_LANES  = 2'h2
   } amw_term_type;

   // Write request from the user side
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [1:0]        lanes;   // Bit 1 high lane, bit 0 low lane
      amw_term_type      term;
   } amw_req_type;

   // Memory pins driven by the controller
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic [DATA_W-1:0] dq_oe;
      logic              chip_sel_n;
      logic              write_strobe_n;
      logic              out_gate_n;
      logic              high_lane_sel_n;
      logic              low_lane_sel_n;
   } amw_pins_type;

   // Whole controller state
   typedef struct packed {
      amw_state_type     state;
      amw_req_type       req;
      amw_pins_type      pins;
      logic [CNT_W-1:0]  cnt;
      logic [CNT_W-1:0]  cyc_cnt;
      logic [WAIT_W-1:0] wait_cnt;
      logic              ready;
      logic              done;
   } amw_regs_type;
endpackage : amw_pkg
`default_nettype wire

// file: core/amw_ctrl.sv
// Write controller driving an asynchronous parallel nonvolatile memory
// Function
// - Write strobe, chip select and lane selects stay high at least 2 ns after rising.
// - Chip select falling edges and write cycles are spaced at least 35 ns.
// - Address is stable 18 ns (gate high) or 20 ns (gate low) before write end, 0 ns setup.
// - A strobe- or lane-terminated write holds its terminating strobe low at least 15 ns.
// - Data is valid 10 ns before write end, 0 ns hold, address kept 12 ns afterwards.
// - A select-terminated write holds chip select low at least 15 ns.
// - Both lane selects move together with no more than 2 ns skew.
// - Write limits are measured from last valid address to next address change.
// - Strobe, select or lane selects bound the write and set the reference edges.
// - Write strobe stays high in read cycles.
// - No access starts until 2 ms after power is valid, strobes held high meanwhile.
`default_nettype none
module amw_ctrl #(
   parameter int STARTUP_CYCLES = amw_pkg::STARTUP_CYC
) (
   input  wire logic                          clk_sys,
   input  wire logic                          rstn,
   input  wire logic                          req_valid,
   input  wire amw_pkg::amw_req_type          req,
   output var  logic                          req_ready,
   output var  logic                          write_done,
   output var  logic [amw_pkg::ADDR_W-1:0]    mem_addr,
   output var  logic [amw_pkg::DATA_W-1:0]    mem_dq_out,
   output var  logic [amw_pkg::DATA_W-1:0]    mem_dq_oe,
   output var  logic                          chip_sel_n,
   output var  logic                          write_strobe_n,
   output var  logic                          out_gate_n,
   output var  logic                          high_lane_sel_n,
   output var  logic                          low_lane_sel_n
);
   amw_pkg::amw_regs_type r_reg;
   amw_pkg::amw_regs_type r_next;

   // Saturating up-count of cycle counters
   function automatic logic [amw_pkg::CNT_W-1:0] inc_sat(input logic [amw_pkg::CNT_W-1:0] v);
      inc_sat = (&v) ? v : v + 16'h0001;
   endfunction : inc_sat

   // Cycle count as counter width
   function automatic logic [amw_pkg::CNT_W-1:0] cyc(input int n);
      cyc = n[amw_pkg::CNT_W-1:0];
   endfunction : cyc

   // Idle pin values: all strobes high, bus released
   function automatic amw_pkg::amw_pins_type idle_pins(input logic [amw_pkg::ADDR_W-1:0] a);
      idle_pins                 = '0;
      idle_pins.addr            = a;
      idle_pins.chip_sel_n      = 1'b1;
      idle_pins.write_strobe_n  = 1'b1;
      idle_pins.out_gate_n      = 1'b1;
      idle_pins.high_lane_sel_n = 1'b1;
      idle_pins.low_lane_sel_n  = 1'b1;
   endfunction : idle_pins

   // Next-state logic
   always_comb
   begin
      r_next         = r_reg;
      r_next.done    = 1'b0;
      r_next.cnt     = inc_sat(r_reg.cnt);
      r_next.cyc_cnt = inc_sat(r_reg.cyc_cnt);
      unique case (r_reg.state)
         amw_pkg::ST_STARTUP:
         begin
            // Strobes stay high through the power-up wait
            r_next.pins = idle_pins(r_reg.pins.addr);
            if (r_reg.wait_cnt >= STARTUP_CYCLES[amw_pkg::WAIT_W-1:0] - 24'h000001)
            begin
               r_next.state = amw_pkg::ST_IDLE;
               r_next.ready = 1'b1;
            end
            else
            begin
               r_next.wait_cnt = r_reg.wait_cnt + 24'h000001;
            end
         end
         amw_pkg::ST_IDLE:
         begin
            if (req_valid && r_reg.ready)
            begin
               // Address and data placed while every strobe is high
               r_next.req              = req;
               r_next.ready            = 1'b0;
               r_next.pins.addr        = req.addr;
               r_next.pins.dq_out      = req.data;
               r_next.pins.dq_oe       = {amw_pkg::DATA_W{1'b1}};
               r_next.state            = amw_pkg::ST_SETUP;
            end
         end
         amw_pkg::ST_SETUP:
         begin
            // Wait out the start-to-start spacing, then open the write
            if (r_reg.cyc_cnt >= cyc(amw_pkg::CYCLE_CYC))
            begin
               r_next.state   = amw_pkg::ST_LOW;
               r_next.cnt     = '0;
               r_next.cyc_cnt = '0;
               // All strobes fall on one edge; the term field picks which edge ends it
               unique case (r_reg.req.term)
                  amw_pkg::TERM_SELECT:
                  begin
                     r_next.pins.write_strobe_n  = 1'b0;
                     r_next.pins.chip_sel_n      = 1'b0;
                  end
                  amw_pkg::TERM_LANES:
                  begin
                     r_next.pins.write_strobe_n  = 1'b0;
                     r_next.pins.chip_sel_n      = 1'b0;
                  end
                  default:
                  begin
                     r_next.pins.chip_sel_n      = 1'b0;
                     r_next.pins.write_strobe_n  = 1'b0;
                  end
               endcase
               // Both lane selects from one register edge: no skew
               r_next.pins.high_lane_sel_n = ~r_reg.req.lanes[1];
               r_next.pins.low_lane_sel_n  = ~r_reg.req.lanes[0];
            end
         end
         amw_pkg::ST_LOW:
         begin
            // Hold the overlap long enough for pulse, address and data limits
            if (r_reg.cnt >= cyc(amw_pkg::LOW_CYC - 1))
            begin
               r_next.state = amw_pkg::ST_RECOVER;
               r_next.cnt   = '0;
               unique case (r_reg.req.term)
                  amw_pkg::TERM_SELECT:
                  begin
                     r_next.pins.chip_sel_n = 1'b1;
                  end
                  amw_pkg::TERM_LANES:
                  begin
                     r_next.pins.high_lane_sel_n = 1'b1;
                     r_next.pins.low_lane_sel_n  = 1'b1;
                  end
                  default:
                  begin
                     r_next.pins.write_strobe_n = 1'b1;
                  end
               endcase
            end
         end
         amw_pkg::ST_RECOVER:
         begin
            // Release the rest one cycle after the write ended
            if (r_reg.cnt == '0)
            begin
               r_next.pins = idle_pins(r_reg.pins.addr);
               r_next.pins.dq_out = r_reg.pins.dq_out;
            end
            // Address held through recovery and the high-hold interval
            if (r_reg.cnt >= cyc(amw_pkg::REC_CYC))
            begin
               r_next.pins.dq_oe = '0;
               r_next.state      = amw_pkg::ST_IDLE;
               r_next.ready      = 1'b1;
               r_next.done       = 1'b1;
            end
         end
         default:
         begin
            r_next.state = amw_pkg::ST_STARTUP;
         end
      endcase
   end

   // State register with synchronous reset
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         r_reg          <= '0;
         r_reg.state    <= amw_pkg::ST_STARTUP;
         r_reg.pins     <= idle_pins('0);
         r_reg.cyc_cnt  <= '1;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from the state register
   assign req_ready       = r_reg.ready;
   assign write_done      = r_reg.done;
   assign mem_addr        = r_reg.pins.addr;
   assign mem_dq_out      = r_reg.pins.dq_out;
   assign mem_dq_oe       = r_reg.pins.dq_oe;
   assign chip_sel_n      = r_reg.pins.chip_sel_n;
   assign write_strobe_n  = r_reg.pins.write_strobe_n;
   assign out_gate_n      = r_reg.pins.out_gate_n;
   assign high_lane_sel_n = r_reg.pins.high_lane_sel_n;
   assign low_lane_sel_n  = r_reg.pins.low_lane_sel_n;
endmodule : amw_ctrl
`default_nettype wire

// file: verif/amw_sva.sv
// Assertion checker for the memory write controller
`default_nettype none
module amw_sva #(
   parameter int STARTUP_CYCLES = amw_pkg::STARTUP_CYC
) (
   input wire logic                       clk_sys,
   input wire logic                       rstn,
   input wire logic                       req_valid,
   input wire amw_pkg::amw_req_type       req,
   input wire logic                       req_ready,
   input wire logic                       write_done,
   input wire logic [amw_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [amw_pkg::DATA_W-1:0] mem_dq_out,
   input wire logic [amw_pkg::DATA_W-1:0] mem_dq_oe,
   input wire logic                       chip_sel_n,
   input wire logic                       write_strobe_n,
   input wire logic                       out_gate_n,
   input wire logic                       high_lane_sel_n,
   input wire logic                       low_lane_sel_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] up_reg;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   // Cycles since reset release, saturating
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         up_reg <= 16'h0000;
      else if (up_reg != 16'hffff)
         up_reg <= up_reg + 16'h0001;
   end
   // Steps of one write
   sequence overlap_s;
      !chip_sel_n && !write_strobe_n;
   endsequence
   sequence end_s;
      write_strobe_n || chip_sel_n || (high_lane_sel_n && low_lane_sel_n);
   endsequence
   sequence idle_s;
      chip_sel_n && write_strobe_n && high_lane_sel_n && low_lane_sel_n;
   endsequence
   write_walk_a: assert property ($fell(chip_sel_n) |-> overlap_s ##1 end_s ##1 idle_s)
      else $error("write strobes out of order");
   take_done_a: assert property (req_valid && req_ready |-> ##2 $fell(chip_sel_n) ##3 write_done)
      else $error("write not finished on time");
   addr_hold_a: assert property (!chip_sel_n || !write_strobe_n |-> $stable(mem_addr))
      else $error("address moved during write");
   addr_recover_a: assert property ($rose(chip_sel_n) || $rose(write_strobe_n) |=> $stable(mem_addr))
      else $error("address moved in recovery");
   data_valid_a: assert property (overlap_s |-> mem_dq_oe == 16'hffff && $stable(mem_dq_out))
      else $error("write data not held");
   lane_skew_a: assert property ($rose(high_lane_sel_n) && !$past(low_lane_sel_n) |-> $rose(low_lane_sel_n))
      else $error("lane selects rose apart");
   lane_start_a: assert property ($fell(high_lane_sel_n) || $fell(low_lane_sel_n) |-> $fell(chip_sel_n))
      else $error("lane select fell alone");
   high_hold_a: assert property (($rose(write_strobe_n) |=> write_strobe_n) and ($rose(chip_sel_n) |=> chip_sel_n))
      else $error("strobe glitched low");
   gate_high_a: assert property (out_gate_n)
      else $error("output gate driven low");
   startup_a: assert property (req_ready |-> int'(up_reg) >= STARTUP_CYCLES)
      else $error("ready before startup wait");
   busy_hold_a: assert property (req_valid && req_ready |=> (!req_ready) [*4] ##1 req_ready)
      else $error("ready not held low through the write");
   done_pulse_a: assert property (write_done |=> !write_done)
      else $error("write done longer than one cycle");
endmodule : amw_sva
bind amw_ctrl amw_sva #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk (
   .clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
   .write_done(write_done), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
   .chip_sel_n(chip_sel_n), .write_strobe_n(write_strobe_n), .out_gate_n(out_gate_n),
   .high_lane_sel_n(high_lane_sel_n), .low_lane_sel_n(low_lane_sel_n));
`default_nettype wire

// file: verif/amw_mem.sv
// Behavioural model of the nonvolatile memory seen from its pins
`default_nettype none
module amw_mem (
   input wire logic [amw_pkg::ADDR_W-1:0] addr,
   input wire logic [amw_pkg::DATA_W-1:0] dq_in,
   input wire logic                       chip_sel_n,
   input wire logic                       write_strobe_n,
   input wire logic                       out_gate_n,
   input wire logic                       high_lane_sel_n,
   input wire logic                       low_lane_sel_n,
   output var logic                       dq_drive
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] lo [int];
   logic [7:0] hi [int];
   // Store each selected lane while select and strobe overlap low; last value wins
   always @*
   begin
      if (!chip_sel_n && !write_strobe_n && !low_lane_sel_n)
         lo[int'(addr)] = dq_in[7:0];
      if (!chip_sel_n && !write_strobe_n && !high_lane_sel_n)
         hi[int'(addr)] = dq_in[15:8];
   end
   // Outputs float while the strobe is low; only a read with gate low drives
   assign dq_drive = !out_gate_n && write_strobe_n && !chip_sel_n;
endmodule : amw_mem
`default_nettype wire

// file: verif/tb_async_mram_write_cycle.sv
// Testbench for the memory write controller
`default_nettype none
module tb_async_mram_write_cycle;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic req_valid = 1'b0;
   amw_pkg::amw_req_type req = '0;
   logic req_ready, write_done, cs_n, ws_n, gate_n, hi_n, lo_n, dq_drive;
   logic [17:0] mem_addr;
   logic [15:0] dq_out, dq_oe, dq_bus;
   int n_errors = 0;
   int n_tests = 0;
   int n_cyc = 0;
   always #25 clk_sys = ~clk_sys;
   // Released data line shows the inverse of the last value
   assign dq_bus = (dq_oe == 16'hffff) ? dq_out : ~dq_out;
   amw_ctrl #(.STARTUP_CYCLES(4)) dut (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .write_done(write_done), .mem_addr(mem_addr),
      .mem_dq_out(dq_out), .mem_dq_oe(dq_oe), .chip_sel_n(cs_n), .write_strobe_n(ws_n),
      .out_gate_n(gate_n), .high_lane_sel_n(hi_n), .low_lane_sel_n(lo_n));
   amw_mem mem_i (.addr(mem_addr), .dq_in(dq_bus), .chip_sel_n(cs_n), .write_strobe_n(ws_n),
      .out_gate_n(gate_n), .high_lane_sel_n(hi_n), .low_lane_sel_n(lo_n), .dq_drive(dq_drive));
   task automatic stop_test();
      if (n_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // Hang guard
   always @(posedge clk_sys)
   begin
      n_cyc++;
      if (n_cyc == 3000)
      begin
         n_errors++;
         stop_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [15:0] rd(input int a);
      return {mem_i.hi[a], mem_i.lo[a]};
   endfunction : rd
   task automatic wait_done();
      int k;
      k = 0;
      while (write_done !== 1'b1 && k < 20)
      begin
         @(negedge clk_sys);
         k++;
      end
      chk({15'h0000, write_done}, 16'h0001);
   endtask : wait_done
   // One write, entered at a falling edge
   task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic [1:0] l, input int t);
      int k;
      k = 0;
      while (req_ready !== 1'b1 && k < 100)
      begin
         @(negedge clk_sys);
         k++;
      end
      req = '{a, d, l, amw_pkg::amw_term_type'(t)};
      req_valid = 1'b1;
      @(negedge clk_sys);
      req_valid = 1'b0;
      wait_done();
   endtask : wr
   // Strobes idle through reset, ready only after the startup wait
   task automatic t_startup();
      chk({11'h000, cs_n, ws_n, hi_n, lo_n, req_ready}, 16'h001e);
      rstn = 1'b1;
      // Ready must rise exactly after the fourth edge of the startup wait
      repeat (3) @(negedge clk_sys);
      chk({15'h0000, req_ready}, 16'h0000);
      @(negedge clk_sys);
      chk({15'h0000, req_ready}, 16'h0001);
   endtask : t_startup
   // Each way of ending a write stores the full word
   task automatic t_terms();
      for (int t = 0; t < 3; t++)
      begin
         wr(18'(t + 1), 16'ha5c0 + 16'(t), 2'h3, t);
         chk(rd(t + 1), 16'ha5c0 + 16'(t));
         chk({15'h0000, dq_drive}, 16'h0000);
      end
   endtask : t_terms
   // Single lane writes keep the other byte
   task automatic t_lanes();
      wr(18'h00008, 16'h1234, 2'h3, 0);
      wr(18'h00008, 16'habcd, 2'h1, 2);
      chk(rd(8), 16'h12cd);
      wr(18'h00008, 16'h5678, 2'h2, 1);
      chk(rd(8), 16'h56cd);
   endtask : t_lanes
   // Request held while busy waits, then is taken back to back
   task automatic t_b2b();
      wr(18'h3ffff, 16'h1111, 2'h3, 1);
      req = '{18'h00010, 16'h2222, 2'h3, amw_pkg::TERM_LANES};
      req_valid = 1'b1;
      @(negedge clk_sys);
      req_valid = 1'b0;
      @(negedge clk_sys);
      req = '{18'h00011, 16'h3333, 2'h3, amw_pkg::TERM_STROBE};
      req_valid = 1'b1;
      wait_done();
      chk(rd(16), 16'h2222);
      @(negedge clk_sys);
      req_valid = 1'b0;
      wait_done();
      chk(rd(17), 16'h3333);
      chk(rd(32'h3ffff), 16'h1111);
   endtask : t_b2b
   // Reset in mid-write releases every strobe and restarts the wait
   task automatic t_reset_mid();
      req = '{18'h00020, 16'h4444, 2'h3, amw_pkg::TERM_STROBE};
      req_valid = 1'b1;
      @(negedge clk_sys);
      req_valid = 1'b0;
      @(negedge clk_sys);
      rstn = 1'b0;
      @(negedge clk_sys);
      chk({11'h000, cs_n, ws_n, hi_n, lo_n, req_ready}, 16'h001e);
      rstn = 1'b1;
      wr(18'h00021, 16'h5555, 2'h3, 0);
      chk(rd(33), 16'h5555);
   endtask : t_reset_mid
   initial
   begin
      repeat (20) @(negedge clk_sys);
      t_startup();
      t_terms();
      t_lanes();
      t_b2b();
      t_reset_mid();
      stop_test();
   end
endmodule : tb_async_mram_write_cycle
`default_nettype wire
